// ### hdl/cfdr_top.sv
// Clock failure detection and recovery with an APB register port.
// Assumes oscillator activity inputs are sampled levels synchronous to mclk_i.
//
// What this block and the software driving it do
// R1: Software disables both failure detectors before changing clock source.
// R2: Detection may be re-enabled any time after a source select write.
// R3: Internal precision oscillator runs from reset with no software action.
// R4: Source changes never stop the internal precision oscillator.
// R5: Primary oscillator failure raises a non-maskable event to the CPU.
// R6: Primary failure substitutes the watchdog oscillator automatically.
// R7: No substitution when the watchdog oscillator is disabled.
// R8: No substitution when the watchdog oscillator is already selected.
// R9: CPU keeps running on the slower substitute clock after recovery.
// R10: Recovery needs only the watchdog oscillator, not its reset function.
// R11: Primary failure flagged when system clock drops below about 1 kHz.
// R12: Software leaves primary detection off for very slow external clocks.
// R13: Watchdog oscillator failure raises an event but switches nothing.
// R14: After watchdog oscillator failure primary failures are no longer detected.
// R15: Software clears watchdog detection when that oscillator is selected or off.
// R16: Each failure sets a sticky readable flag until software clears it.
`timescale 1ns/10ps
`default_nettype none

module cfdr_top #(
    parameter int FAIL_CYCLES = cfdr_pkg::CFDR_FAIL_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic sys_clk_act_i,
    input wire logic wdt_osc_act_i,
    output logic irq_o,
    output logic primary_fail_nmi_o,
    output logic wdt_fail_nmi_o,
    output logic [cfdr_pkg::CFDR_CTRL_SEL_W-1:0] sys_clk_source_sel_o,
    output logic internal_precision_osc_en_o,
    output logic wdt_osc_en_o,
    output logic recovery_active_o
);
    import cfdr_pkg::*;

    if (FAIL_CYCLES < 2) begin
        $error("cfdr_top: FAIL_CYCLES must be at least 2");
    end

    // Control fields
    logic ipo_en;
    logic wdt_osc_en;
    logic primary_fail_detect_en;
    logic wdt_osc_fail_detect_en;
    logic [CFDR_CTRL_SEL_W-1:0] sys_clk_source_sel;
    logic [CFDR_EVT_W-1:0] stat;
    logic [CFDR_EVT_W-1:0] mask;
    logic wdt_dead;
    cfdr_state_e state;
    cfdr_state_e next_state;

    // APB decode: zero-wait, answer in the cycle after setup
    wire setup = psel_i && !penable_i;
    wire access = psel_i && penable_i && pready_o;
    wire hit_ctrl = (paddr_i == CFDR_CTRL_OFS);
    wire hit_stat = (paddr_i == CFDR_STAT_OFS);
    wire hit_mask = (paddr_i == CFDR_MASK_OFS);
    wire hit_any = hit_ctrl || hit_stat || hit_mask;
    wire ctrl_wr = access && pwrite_i && hit_ctrl && !pslverr_o;
    wire stat_wr = access && pwrite_i && hit_stat && !pslverr_o;
    wire mask_wr = access && pwrite_i && hit_mask && !pslverr_o;

    wire [CFDR_EVT_W-1:0] stat_clr = stat_wr ? pwdata_i[CFDR_EVT_W-1:0] : '0;
    wire [CFDR_CTRL_SEL_W-1:0] wr_sel = pwdata_i[CFDR_CTRL_SEL_LSB +: CFDR_CTRL_SEL_W];

    // Detector enables: watchdog failure disables the primary detector for good
    wire pri_mon_en = primary_fail_detect_en && !wdt_dead && (state == CFDR_ST_NORMAL); // R14
    wire wdt_mon_en = wdt_osc_fail_detect_en && wdt_osc_en
        && (sys_clk_source_sel != CFDR_SRC_WDT);
    wire pri_fail_evt;
    wire wdt_fail_evt;

    cfdr_act_mon #(
        .LIMIT(FAIL_CYCLES)
    ) u_pri_mon (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .enable_i(pri_mon_en),
        .act_i(sys_clk_act_i),
        .fail_o(pri_fail_evt) // R11
    );

    cfdr_act_mon #(
        .LIMIT(FAIL_CYCLES)
    ) u_wdt_mon (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .enable_i(wdt_mon_en),
        .act_i(wdt_osc_act_i),
        .fail_o(wdt_fail_evt)
    );

    // Recovery only with the watchdog oscillator running and not already selected;
    // the watchdog reset function plays no part here
    wire can_recover = wdt_osc_en && (sys_clk_source_sel != CFDR_SRC_WDT); // R7 R8 R10

    always_comb begin
        next_state = state;
        case (state)
            CFDR_ST_NORMAL: begin
                if (pri_fail_evt && can_recover) begin
                    next_state = CFDR_ST_RECOVERED; // R6
                end
            end
            CFDR_ST_RECOVERED: begin
                // A new source select write hands the clock back to software
                if (ctrl_wr) begin
                    next_state = CFDR_ST_NORMAL;
                end
            end
            default: begin
                next_state = CFDR_ST_NORMAL;
            end
        endcase
    end

    wire [CFDR_CTRL_SEL_W-1:0] next_sel = ctrl_wr ? wr_sel : sys_clk_source_sel;
    wire [CFDR_CTRL_SEL_W-1:0] next_eff_sel =
        (next_state == CFDR_ST_RECOVERED) ? CFDR_SRC_WDT : next_sel; // R9

    // Events set the sticky flags; a set wins over a clear in the same cycle
    wire [CFDR_EVT_W-1:0] evt = {wdt_fail_evt, pri_fail_evt};
    wire [CFDR_EVT_W-1:0] next_stat = evt | (stat & ~stat_clr); // R16

    wire [31:0] ctrl_rd = {
        {(32 - CFDR_CTRL_SEL_LSB - CFDR_CTRL_SEL_W){1'b0}},
        sys_clk_source_sel,
        wdt_osc_fail_detect_en,
        primary_fail_detect_en,
        wdt_osc_en,
        ipo_en
    };
    wire [31:0] stat_rd = {
        {(32 - CFDR_STAT_EFF_SEL_LSB - CFDR_CTRL_SEL_W){1'b0}},
        sys_clk_source_sel_o,
        wdt_dead,
        (state == CFDR_ST_RECOVERED),
        stat
    };
    wire [31:0] mask_rd = {{(32 - CFDR_EVT_W){1'b0}}, mask};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
        hit_stat ? stat_rd :
        hit_mask ? mask_rd : 32'h0000_0000;

    // Bus slave
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= setup;
            pslverr_o <= setup && !hit_any;
            prdata_o <= (setup && !pwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end

    // Control register; the precision oscillator enable changes only by a write
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ipo_en <= CFDR_CTRL_RESET[CFDR_CTRL_IPO_EN_BIT]; // R3
            wdt_osc_en <= CFDR_CTRL_RESET[CFDR_CTRL_WDT_OSC_EN_BIT];
            primary_fail_detect_en <= CFDR_CTRL_RESET[CFDR_CTRL_PRI_DET_BIT];
            wdt_osc_fail_detect_en <= CFDR_CTRL_RESET[CFDR_CTRL_WDT_DET_BIT];
            sys_clk_source_sel <= CFDR_SRC_IPO;
        end else if (ctrl_wr) begin
            ipo_en <= pwdata_i[CFDR_CTRL_IPO_EN_BIT]; // R4
            wdt_osc_en <= pwdata_i[CFDR_CTRL_WDT_OSC_EN_BIT];
            primary_fail_detect_en <= pwdata_i[CFDR_CTRL_PRI_DET_BIT]; // R2
            wdt_osc_fail_detect_en <= pwdata_i[CFDR_CTRL_WDT_DET_BIT];
            sys_clk_source_sel <= wr_sel;
        end
    end

    // Supervision state, flags and outputs
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= CFDR_ST_NORMAL;
            stat <= '0;
            mask <= CFDR_MASK_RESET;
            wdt_dead <= 1'b0;
            irq_o <= 1'b0;
            primary_fail_nmi_o <= 1'b0;
            wdt_fail_nmi_o <= 1'b0;
            sys_clk_source_sel_o <= CFDR_SRC_IPO;
            internal_precision_osc_en_o <= 1'b1;
            wdt_osc_en_o <= 1'b1;
            recovery_active_o <= 1'b0;
        end else begin
            state <= next_state;
            stat <= next_stat;
            if (mask_wr) begin
                mask <= pwdata_i[CFDR_EVT_W-1:0];
            end
            wdt_dead <= wdt_dead || wdt_fail_evt; // R14
            irq_o <= |(next_stat & (mask_wr ? pwdata_i[CFDR_EVT_W-1:0] : mask));
            primary_fail_nmi_o <= pri_fail_evt; // R5
            wdt_fail_nmi_o <= wdt_fail_evt; // R13
            sys_clk_source_sel_o <= next_eff_sel;
            internal_precision_osc_en_o <= ctrl_wr ? pwdata_i[CFDR_CTRL_IPO_EN_BIT] : ipo_en;
            wdt_osc_en_o <= ctrl_wr ? pwdata_i[CFDR_CTRL_WDT_OSC_EN_BIT] : wdt_osc_en;
            recovery_active_o <= (next_state == CFDR_ST_RECOVERED);
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_recover;
        (state == CFDR_ST_NORMAL) && pri_fail_evt && can_recover
            |=> (sys_clk_source_sel_o == CFDR_SRC_WDT) && recovery_active_o;
    endproperty
    a_recover: assert property (p_recover) else $error("no switch to wdt osc"); // R6

    property p_no_recover_off;
        (state == CFDR_ST_NORMAL) && pri_fail_evt && !wdt_osc_en |=> !recovery_active_o;
    endproperty
    a_no_recover_off: assert property (p_no_recover_off) else $error("recovery with osc off"); // R7

    property p_no_recover_sel;
        (state == CFDR_ST_NORMAL) && (sys_clk_source_sel == CFDR_SRC_WDT)
            |=> (state == CFDR_ST_NORMAL);
    endproperty
    a_no_recover_sel: assert property (p_no_recover_sel) else $error("recovery from wdt"); // R8

    property p_recov_clock;
        (state == CFDR_ST_RECOVERED) |-> (sys_clk_source_sel_o == CFDR_SRC_WDT);
    endproperty
    a_recov_clock: assert property (p_recov_clock) else $error("recovered off wdt"); // R9

    property p_pri_event;
        pri_fail_evt |=> primary_fail_nmi_o && stat[CFDR_STAT_PRI_FAIL_BIT];
    endproperty
    a_pri_event: assert property (p_pri_event) else $error("missing primary event"); // R5 R16

    property p_wdt_no_switch;
        wdt_fail_evt && !pri_fail_evt && !ctrl_wr |=> wdt_fail_nmi_o && $stable(state);
    endproperty
    a_wdt_no_switch: assert property (p_wdt_no_switch) else $error("wdt fail switched"); // R13

    property p_dead_blocks;
        wdt_dead |-> ##1 !pri_fail_evt [*2];
    endproperty
    a_dead_blocks: assert property (p_dead_blocks) else $error("primary seen after wdt fail"); // R14

    property p_ipo_kept;
        !ctrl_wr |=> $stable(ipo_en);
    endproperty
    a_ipo_kept: assert property (p_ipo_kept) else $error("ipo enable moved"); // R4

    property p_ipo_reset;
        $past(rst_i) |-> internal_precision_osc_en_o;
    endproperty
    a_ipo_reset: assert property (p_ipo_reset) else $error("ipo off after reset"); // R3

    property p_det_write;
        ctrl_wr |=> primary_fail_detect_en == $past(pwdata_i[CFDR_CTRL_PRI_DET_BIT]);
    endproperty
    a_det_write: assert property (p_det_write) else $error("enable write lost"); // R2

    property p_flag_sticky;
        stat[CFDR_STAT_WDT_FAIL_BIT] && !stat_wr |=> stat[CFDR_STAT_WDT_FAIL_BIT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // R16

    property p_ready_answer;
        psel_i && !penable_i |=> pready_o;
    endproperty
    a_ready_answer: assert property (p_ready_answer) else $error("setup not answered"); // R2

    property p_ready_one;
        pready_o |=> !pready_o;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready held too long"); // R2

    property p_sel_write;
        ctrl_wr && !pri_fail_evt |=> sys_clk_source_sel_o == $past(wr_sel);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("source select write lost"); // R2

    property p_recov_ends;
        (state == CFDR_ST_RECOVERED) && ctrl_wr |=> !recovery_active_o;
    endproperty
    a_recov_ends: assert property (p_recov_ends) else $error("recovery not ended"); // R9

    property p_recov_holds;
        (state == CFDR_ST_RECOVERED) && !ctrl_wr
            |=> recovery_active_o && (sys_clk_source_sel_o == CFDR_SRC_WDT);
    endproperty
    a_recov_holds: assert property (p_recov_holds) else $error("recovery dropped"); // R9

    property p_pri_pulse;
        primary_fail_nmi_o |=> !primary_fail_nmi_o;
    endproperty
    a_pri_pulse: assert property (p_pri_pulse) else $error("primary event too long"); // R5

    property p_wdt_pulse;
        wdt_fail_nmi_o |=> !wdt_fail_nmi_o;
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("wdt event too long"); // R13

    property p_dead_set;
        wdt_fail_evt |=> wdt_dead;
    endproperty
    a_dead_set: assert property (p_dead_set) else $error("wdt failure not latched"); // R14

    property p_dead_kept;
        wdt_dead |=> wdt_dead;
    endproperty
    a_dead_kept: assert property (p_dead_kept) else $error("wdt failure forgotten"); // R14

    property p_irq_level;
        irq_o == |(stat & mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong"); // R16

    property p_pri_sticky;
        stat[CFDR_STAT_PRI_FAIL_BIT] && !stat_wr |=> stat[CFDR_STAT_PRI_FAIL_BIT];
    endproperty
    a_pri_sticky: assert property (p_pri_sticky) else $error("primary flag dropped"); // R16

    property p_osc_out_kept;
        !ctrl_wr |=> $stable(internal_precision_osc_en_o);
    endproperty
    a_osc_out_kept: assert property (p_osc_out_kept) else $error("ipo output moved"); // R4

endmodule

`default_nettype wire

// ### hdl/cfdr_pkg.sv
// Package for the clock failure detect and recovery block.
// Holds register offsets, field positions, reset values, source codes and timing.
package cfdr_pkg;

    // Register byte offsets on the APB port
    localparam logic [7:0] CFDR_CTRL_OFS = 8'h00;
    localparam logic [7:0] CFDR_STAT_OFS = 8'h04;
    localparam logic [7:0] CFDR_MASK_OFS = 8'h08;

    // Control register fields
    localparam int CFDR_CTRL_IPO_EN_BIT = 0;
    localparam int CFDR_CTRL_WDT_OSC_EN_BIT = 1;
    localparam int CFDR_CTRL_PRI_DET_BIT = 2;
    localparam int CFDR_CTRL_WDT_DET_BIT = 3;
    localparam int CFDR_CTRL_SEL_LSB = 4;
    localparam int CFDR_CTRL_SEL_W = 2;
    localparam logic [31:0] CFDR_CTRL_RESET = 32'h0000_0003;

    // Status and mask register fields
    localparam int CFDR_STAT_PRI_FAIL_BIT = 0;
    localparam int CFDR_STAT_WDT_FAIL_BIT = 1;
    localparam int CFDR_STAT_RECOV_BIT = 2;
    localparam int CFDR_STAT_WDT_DEAD_BIT = 3;
    localparam int CFDR_STAT_EFF_SEL_LSB = 4;
    localparam int CFDR_EVT_W = 2;
    localparam logic [1:0] CFDR_MASK_RESET = 2'h0;

    // System clock sources
    typedef enum logic [1:0] {
        CFDR_SRC_IPO = 2'h0,
        CFDR_SRC_XTAL = 2'h1,
        CFDR_SRC_EXT = 2'h2,
        CFDR_SRC_WDT = 2'h3
    } cfdr_src_e;

    // Clock supervision states
    typedef enum logic [1:0] {
        CFDR_ST_NORMAL = 2'b01,
        CFDR_ST_RECOVERED = 2'b10
    } cfdr_state_e;

    // Failure threshold: a source slower than 1 kHz counts as failed
    localparam int CFDR_FAIL_PERIOD_NS = 1000000;
    localparam int CFDR_MCLK_PERIOD_NS = 10;
    localparam int CFDR_FAIL_CYCLES = CFDR_FAIL_PERIOD_NS / CFDR_MCLK_PERIOD_NS;

endpackage

// ### hdl/cfdr_act_mon.sv
// Activity monitor: flags a source whose sampled level stops toggling.
// Assumes act_i is already synchronous to mclk_i.
`timescale 1ns/10ps
`default_nettype none

module cfdr_act_mon #(
    parameter int LIMIT = 100000
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic act_i,
    output logic fail_o
);
    import cfdr_pkg::*;

    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    // Refused at elaboration: a limit below 2 leaves no quiet period to count
    if (LIMIT < 2) begin
        $error("cfdr_act_mon: LIMIT must be at least 2");
    end

    logic act_q;
    logic [CW-1:0] cnt;
    logic fired;

    wire act_edge = act_i ^ act_q;
    // An edge in the last counted cycle still proves the source alive
    wire expire = enable_i && !fired && !act_edge && (cnt == LAST);

    // Any edge restarts the count, so only a full quiet period fails
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            act_q <= 1'b0;
            cnt <= '0;
            fired <= 1'b0;
            fail_o <= 1'b0;
        end else begin
            act_q <= act_i;
            fail_o <= expire;
            if (!enable_i || act_edge) begin
                cnt <= '0;
                fired <= 1'b0;
            end else if (expire) begin
                fired <= 1'b1;
            end else if (!fired) begin
                cnt <= cnt + CW'(1);
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // An active source never reports failure on the next edge
    property p_edge_no_fail;
        act_edge |=> !fail_o;
    endproperty
    a_edge_no_fail: assert property (p_edge_no_fail) else $error("fail after edge"); // R11

endmodule

`default_nettype wire

// ### tb/cfdr_osc_model.sv
// Oscillator activity model: system and watchdog sources, each toggling every cycle.
// Assumes the bench stops a source to stand in for an oscillator failure.
`timescale 1ns/10ps
`default_nettype none

module cfdr_osc_model (
    input wire logic mclk_i,
    input wire logic sys_run_i,
    input wire logic wdt_run_i,
    output logic sys_act_o,
    output logic wdt_act_o
);
    // A dead source freezes its level, which is exactly what the detector must catch
    initial begin
        sys_act_o = 1'b0;
        wdt_act_o = 1'b0;
    end
    always @(posedge mclk_i) begin
        if (sys_run_i) begin
            sys_act_o <= ~sys_act_o;
        end
        if (wdt_run_i) begin
            wdt_act_o <= ~wdt_act_o;
        end
    end
endmodule

`default_nettype wire

// ### tb/cfdr_top_bench.sv
// Self-checking bench for the clock failure block, with an integer reference model.
// Assumes the design answers APB after one setup cycle and uses FAIL_CYCLES of 20.
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module cfdr_top_bench;
    import cfdr_pkg::*;
    localparam int FC = 20;
    logic mclk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic sys_act, wdt_act, sys_run, wdt_run, pri_nmi, wdt_nmi, ipo_en, wosc_en, recov;
    logic [1:0] sel;
    int num_errors = 0, total_checks = 0, seed = 73809, pri_cnt = 0, wdt_cnt = 0;
    int m_ctrl = 3, m_stat = 0, m_mask = 0;

    cfdr_top #(.FAIL_CYCLES(FC)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .sys_clk_act_i(sys_act), .wdt_osc_act_i(wdt_act), .irq_o(irq_o),
        .primary_fail_nmi_o(pri_nmi), .wdt_fail_nmi_o(wdt_nmi), .sys_clk_source_sel_o(sel),
        .internal_precision_osc_en_o(ipo_en), .wdt_osc_en_o(wosc_en), .recovery_active_o(recov));
    cfdr_osc_model u_osc (.mclk_i(mclk_i), .sys_run_i(sys_run), .wdt_run_i(wdt_run),
        .sys_act_o(sys_act), .wdt_act_o(wdt_act));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        if (pri_nmi === 1'b1) pri_cnt <= pri_cnt + 1;
        if (wdt_nmi === 1'b1) wdt_cnt <= wdt_cnt + 1;
    end

    task automatic stop_test();
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // One APB transfer; upper data bits are random since no register uses them
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n, rd_exp;
        n = 0;
        rd_exp = a == 0 ? m_ctrl : a == 4 ? m_stat : a == 8 ? m_mask : 0;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d | ($random(seed) & 32'hFFFF_FF00);
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        `CHK("pready", 1'b1, pready_o)
        `CHK("pslverr", (a == 0 || a == 4 || a == 8) ? 1'b0 : 1'b1, pslverr_o)
        if (!wr) `CHK("prdata", rd_exp, prdata_o)
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (wr && a == 0) begin
            m_ctrl = d & 32'h3F;
            m_stat = (m_stat & 32'h0B) | (d & 32'h30);
        end
        if (wr && a == 4) m_stat = m_stat & ~(d & 3);
        if (wr && a == 8) m_mask = d & 3;
    endtask

    task automatic check_outs();
        @(posedge mclk_i);
        #1;
        `CHK("sel_o", m_stat[5:4], sel)
        `CHK("recovery", m_stat[2], recov)
        `CHK("irq", ((m_stat & m_mask & 3) != 0) ? 1'b1 : 1'b0, irq_o)
        `CHK("ipo_en", m_ctrl[0], ipo_en)
        `CHK("wdt_osc_en", m_ctrl[1], wosc_en)
        apb(0, 8'h04, 0);
    endtask

    // Freeze one source and look for its failure pulse within the detection window
    task automatic fail_src(input int wdt, input int exp_pulse);
        int n0, n1, d, k;
        n0 = wdt ? wdt_cnt : pri_cnt;
        n1 = wdt ? pri_cnt : wdt_cnt;
        d = -1;
        @(posedge mclk_i);
        if (wdt) wdt_run <= 1'b0;
        else sys_run <= 1'b0;
        for (k = 1; k <= 4 * FC && d < 0; k++) begin
            @(posedge mclk_i);
            #1;
            if ((wdt ? wdt_cnt : pri_cnt) != n0) d = k;
        end
        if (exp_pulse) `CHK("fail_delay_ok", 1, (d >= FC && d <= FC + 4))
        else `CHK("no_pulse", -1, d)
        if (exp_pulse && wdt) m_stat = m_stat | 32'h0A;
        if (exp_pulse && !wdt) m_stat = m_stat | 1;
        if (exp_pulse && !wdt && m_ctrl[1] && m_ctrl[5:4] != 3) m_stat = (m_stat & 32'h0B) | 32'h34;
        check_outs();
        `CHK("nmi_pulses", n0 + exp_pulse, wdt ? wdt_cnt : pri_cnt)
        `CHK("other_nmi", n1, wdt ? pri_cnt : wdt_cnt)
        sys_run <= 1'b1;
        wdt_run <= 1'b1;
    endtask

    initial begin
        rst_i = 1'b1;
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        sys_run = 1'b1;
        wdt_run = 1'b1;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        apb(0, 8'h00, 0);
        apb(0, 8'h08, 0);
        check_outs();
        apb(1, 8'h0C, 32'h5A);
        apb(0, 8'h0C, 0);
        apb(1, 8'h00, 32'h13);
        check_outs();
        apb(1, 8'h00, 32'h17);
        apb(1, 8'h08, 32'h01);
        fail_src(0, 1);
        apb(0, 8'h00, 0);
        apb(1, 8'h04, 32'h01);
        apb(1, 8'h00, 32'h13);
        check_outs();
        apb(1, 8'h08, 32'h00);
        apb(1, 8'h00, 32'h15);
        fail_src(0, 1);
        apb(1, 8'h00, 32'h13);
        apb(1, 8'h04, 32'h03);
        apb(1, 8'h00, 32'h33);
        apb(1, 8'h00, 32'h37);
        fail_src(0, 1);
        apb(1, 8'h00, 32'h33);
        apb(1, 8'h04, 32'h03);
        apb(1, 8'h00, 32'h13);
        apb(1, 8'h00, 32'h23);
        fail_src(0, 0);
        apb(1, 8'h00, 32'h13);
        apb(1, 8'h08, 32'h02);
        apb(1, 8'h00, 32'h1B);
        fail_src(1, 1);
        apb(1, 8'h00, 32'h13);
        apb(1, 8'h00, 32'h17);
        fail_src(0, 0);
        stop_test();
    end

    initial begin
        #100000;
        num_errors++;
        stop_test();
    end
endmodule

`default_nettype wire
